// [hw/cct_timer_channel.sv]
// Single compare/capture timer channel with one up-count, cleared by match B or by a capture when enabled.
// Assumes control inputs and the capture pin are synchronous to clk_sys;
// software access arrives as a plain write strobe with a target select.
module cct_timer_channel #(
  parameter int CNT_W = cct_pkg::CNT_W
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             count_run,
  input  wire logic             mode_sel,
  input  wire logic             buffer_en,
  input  wire logic [1:0]       act_a,
  input  wire logic [1:0]       act_b,
  input  wire logic             cap_pin,
  input  wire logic [1:0]       cap_edge_sel,
  input  wire logic             cap_dest,
  input  wire logic             cap_clear_en,
  input  wire logic             wr_en,
  input  wire logic [2:0]       wr_sel,
  input  wire logic [CNT_W-1:0] wr_data,
  output logic                  pulse_out,
  output logic                  irq_cmp_a,
  output logic                  irq_cmp_b,
  output logic                  irq_capture,
  output logic                  irq_overflow,
  output logic [CNT_W-1:0]      running_count,
  output logic [CNT_W-1:0]      compare_a,
  output logic [CNT_W-1:0]      compare_b
);

  if (CNT_W != cct_pkg::CNT_W) begin : g_width_check
    $error("CNT_W must match the package count width");
  end

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] cmp_a_q;
  logic [CNT_W-1:0] cmp_a_d;
  logic [CNT_W-1:0] cmp_b_q;
  logic [CNT_W-1:0] cmp_b_d;
  logic [CNT_W-1:0] buf_c_q;
  logic [CNT_W-1:0] buf_c_d;
  logic [CNT_W-1:0] buf_d_q;
  logic [CNT_W-1:0] buf_d_d;
  logic             pin_q;
  logic             pin_d;
  logic             irq_a_q;
  logic             irq_a_d;
  logic             irq_b_q;
  logic             irq_b_d;
  logic             irq_cap_q;
  logic             irq_cap_d;
  logic             irq_ovf_q;
  logic             irq_ovf_d;

  logic cap_edge;
  logic pulse_mode;
  logic match_a;
  logic match_b;
  logic cap_hit;
  logic cnt_clear;
  logic cnt_step;
  logic wr_count;
  logic wr_cmp_a;
  logic wr_cmp_b;

  cct_edge_detect u_edge (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .pin_in   (cap_pin),
    .edge_sel (cap_edge_sel),
    .edge_hit (cap_edge)
  );

  function automatic logic apply_act(input logic [1:0] act,
                                     input logic       cur);
    unique case (act)
      cct_pkg::ACT_LOW:    apply_act = 1'b0;
      cct_pkg::ACT_HIGH:   apply_act = 1'b1;
      cct_pkg::ACT_TOGGLE: apply_act = ~cur;
      default:             apply_act = cur;
    endcase
  endfunction

  always_comb begin
    pulse_mode = (mode_sel == cct_pkg::MODE_PULSE);
    // Matches are taken on the present count, so a match at start
    // is seen in the first running cycle
    match_a = count_run & pulse_mode & (count_q == cmp_a_q);
    match_b = count_run & pulse_mode & (count_q == cmp_b_q);
    cap_hit = count_run & ~pulse_mode & cap_edge;
    cnt_clear = match_b | (cap_hit & cap_clear_en);
    cnt_step = count_run & ~cnt_clear;
    wr_count = wr_en & (wr_sel == cct_pkg::WR_COUNT);
    wr_cmp_a = wr_en & (wr_sel == cct_pkg::WR_CMP_A);
    wr_cmp_b = wr_en & (wr_sel == cct_pkg::WR_CMP_B);

    // Software writes win over hardware updates of the same register;
    // software is expected to stop counting before it reloads
    count_d = count_q;
    if (wr_count) begin
      count_d = wr_data;
    end else if (cnt_clear) begin
      count_d = cct_pkg::CNT_ZERO;
    end else if (cnt_step) begin
      count_d = count_q + cct_pkg::CNT_ONE;
    end

    cmp_a_d = cmp_a_q;
    if (wr_cmp_a) begin
      cmp_a_d = wr_data;
    end else if (match_a && buffer_en) begin
      cmp_a_d = buf_c_q;
    end else if (cap_hit && cap_dest == cct_pkg::CAP_TO_A) begin
      cmp_a_d = count_q;
    end

    cmp_b_d = cmp_b_q;
    if (wr_cmp_b) begin
      cmp_b_d = wr_data;
    end else if (match_b && buffer_en) begin
      cmp_b_d = buf_d_q;
    end else if (cap_hit && cap_dest == cct_pkg::CAP_TO_B) begin
      cmp_b_d = count_q;
    end

    buf_c_d = (wr_en && wr_sel == cct_pkg::WR_BUF_C) ? wr_data : buf_c_q;
    buf_d_d = (wr_en && wr_sel == cct_pkg::WR_BUF_D) ? wr_data : buf_d_q;

    // On a simultaneous match only B acts, on the old pin, so equal compares hold
    // the pin steady instead of pulsing
    pin_d = pin_q;
    if (match_a) begin
      pin_d = apply_act(act_a, pin_d);
    end
    if (match_b) begin
      pin_d = apply_act(act_b, match_a ? pin_q : pin_d);
    end

    irq_a_d = match_a;
    irq_b_d = match_b;
    irq_cap_d = cap_hit;
    irq_ovf_d = cnt_step & ~wr_count & (count_q == CNT_MAX);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_q <= cct_pkg::CNT_RST;
      cmp_a_q <= cct_pkg::CMP_RST;
      cmp_b_q <= cct_pkg::CMP_RST;
      buf_c_q <= cct_pkg::CMP_RST;
      buf_d_q <= cct_pkg::CMP_RST;
      pin_q <= 1'b0;
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
      irq_cap_q <= 1'b0;
      irq_ovf_q <= 1'b0;
    end else begin
      count_q <= count_d;
      cmp_a_q <= cmp_a_d;
      cmp_b_q <= cmp_b_d;
      buf_c_q <= buf_c_d;
      buf_d_q <= buf_d_d;
      pin_q <= pin_d;
      irq_a_q <= irq_a_d;
      irq_b_q <= irq_b_d;
      irq_cap_q <= irq_cap_d;
      irq_ovf_q <= irq_ovf_d;
    end
  end

  always_comb begin
    pulse_out = pin_q;
    irq_cmp_a = irq_a_q;
    irq_cmp_b = irq_b_q;
    irq_capture = irq_cap_q;
    irq_overflow = irq_ovf_q;
    running_count = count_q;
    compare_a = cmp_a_q;
    compare_b = cmp_b_q;
  end

  a_match_a_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
    match_a && !match_b && act_a == cct_pkg::ACT_HIGH |=> pulse_out)
    else $error("pin not high after match A");

  a_match_b_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    match_b && act_b == cct_pkg::ACT_LOW |=> !pulse_out)
    else $error("pin not low after match B");

  a_toggle_act: assert property (@(posedge clk_sys) disable iff (sys_rst)
    match_a && !match_b && act_a == cct_pkg::ACT_TOGGLE
    |=> pulse_out != $past(pulse_out))
    else $error("toggle action did not invert the pin");

  a_buffer_c_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    match_a && buffer_en && !wr_cmp_a |=> compare_a == $past(buf_c_q))
    else $error("compare_a not reloaded from buffer_c");

  a_match_b_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    match_b && !wr_count ##0 (buffer_en && !wr_cmp_b)
    |=> running_count == cct_pkg::CNT_ZERO
        && compare_b == $past(buf_d_q))
    else $error("match B did not clear count or reload compare_b");

  a_start_match: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(count_run) && pulse_mode && count_q == cmp_a_q
    |=> irq_cmp_a)
    else $error("match A at start was missed");

  a_capture_copy: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cap_hit && cap_dest == cct_pkg::CAP_TO_A && !wr_cmp_a
    |=> compare_a == $past(count_q) && irq_capture)
    else $error("capture did not copy the count");

  a_capture_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cap_hit && cap_clear_en && !wr_count
    |=> running_count == cct_pkg::CNT_ZERO)
    else $error("capture did not clear the count");

  a_overflow_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
    count_run && !cnt_clear && !wr_count && count_q == CNT_MAX
    |=> running_count == cct_pkg::CNT_ZERO && irq_overflow)
    else $error("count did not wrap with an overflow request");

  a_equal_steady: assert property (@(posedge clk_sys) disable iff (sys_rst)
    match_a && match_b && act_a == cct_pkg::ACT_HIGH
    && act_b == cct_pkg::ACT_LOW |=> !pulse_out)
    else $error("equal compares produced a pulse");

  a_reset_idle: assert property (@(posedge clk_sys)
    $past(sys_rst) |-> !pulse_out && running_count == cct_pkg::CNT_ZERO
      && compare_a == cct_pkg::CMP_RST)
    else $error("state not cleared by reset");

endmodule

// [include/cct_pkg.sv]
// Shared constants for the compare/capture timer channel.
// Assumes a single clock domain and a synchronous, active-high reset.
package cct_pkg;

  localparam int CNT_W = 16;

  // Reset values of the count, compare and buffer registers, then the clear and step values
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  // Values for a single pulse
  localparam logic [CNT_W-1:0] ONESHOT_BUF_C = 16'hffff;
  localparam logic [CNT_W-1:0] ONESHOT_BUF_D = 16'hfffe;

  // Pin action on a compare match
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Channel mode
  localparam logic MODE_NORMAL = 1'b0;
  localparam logic MODE_PULSE = 1'b1;

  // Capture edge selection
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // Capture destination
  localparam logic CAP_TO_A = 1'b0;
  localparam logic CAP_TO_B = 1'b1;

  // Software write targets
  localparam logic [2:0] WR_COUNT = 3'h0;
  localparam logic [2:0] WR_CMP_A = 3'h1;
  localparam logic [2:0] WR_CMP_B = 3'h2;
  localparam logic [2:0] WR_BUF_C = 3'h3;
  localparam logic [2:0] WR_BUF_D = 3'h4;

endpackage

// [hw/cct_edge_detect.sv]
// Edge detector for the capture input pin.
// Assumes the pin is already synchronous to clk_sys.
module cct_edge_detect (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       pin_in,
  input  wire logic [1:0] edge_sel,
  output logic            edge_hit
);

  logic prev_q;
  logic prev_d;

  always_comb begin
    prev_d = pin_in;
    unique case (edge_sel)
      cct_pkg::EDGE_RISE: edge_hit = pin_in & ~prev_q;
      cct_pkg::EDGE_FALL: edge_hit = ~pin_in & prev_q;
      cct_pkg::EDGE_BOTH: edge_hit = pin_in ^ prev_q;
      default:            edge_hit = 1'b0;
    endcase
  end

  // Pin assumed low at reset, so a pin high out of reset reads as rising
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

endmodule

// [verification/cct_pin_model.sv]
// Far side of the channel: drives a square wave on the capture pin and
// measures how many cycles the compare output pin stays high.
// Assumes both pins are synchronous to the rising edge of clk_sys.
module cct_pin_model (
  input  wire logic        clk_sys,
  input  wire logic        pulse_out,
  input  wire logic [15:0] wave_half,
  output logic             cap_pin,
  output logic [15:0]      hi_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] ph;
  logic        was_hi;

  initial begin
    cap_pin = 1'b0;
    ph = 16'h0000;
    hi_cnt = 16'h0000;
    was_hi = 1'b0;
  end

  // Pin changes away from the sampling edge; a zero half period parks it low
  always @(negedge clk_sys) begin
    if (wave_half == 16'h0000) begin
      cap_pin = 1'b0;
      ph = 16'h0000;
    end else if (ph + 16'h0001 >= wave_half) begin
      cap_pin = ~cap_pin;
      ph = 16'h0000;
    end else begin
      ph = ph + 16'h0001;
    end
  end

  // Width restarts at each rise and holds after the fall until the next one
  always @(posedge clk_sys) begin
    if (pulse_out === 1'b1) begin
      hi_cnt <= was_hi ? hi_cnt + 16'h0001 : 16'h0001;
    end
    was_hi <= (pulse_out === 1'b1);
  end
endmodule

// [verification/compare_capture_timer_channel_tb.sv]
// Self-checking bench for the compare/capture timer channel.
// Assumes one 50 MHz clock and the pin model on the far side.
module compare_capture_timer_channel_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0;
  logic        sys_rst, count_run, mode_sel, buffer_en, cap_pin;
  logic        cap_dest, cap_clear_en, wr_en, pulse_out;
  logic        irq_cmp_a, irq_cmp_b, irq_capture, irq_overflow;
  logic [1:0]  act_a, act_b, cap_edge_sel;
  logic [2:0]  wr_sel;
  logic [15:0] wr_data, running_count, compare_a, compare_b;
  logic [15:0] wave_half, hi_cnt, n, m;
  logic [15:0] exp_q[$];
  logic [3:0]  irqs;
  int          err_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          seed = 32'h907b342c;

  assign irqs = {irq_capture, irq_overflow, irq_cmp_b, irq_cmp_a};

  cct_timer_channel i_cct_timer_channel (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .count_run(count_run), .mode_sel(mode_sel),
    .buffer_en(buffer_en), .act_a(act_a), .act_b(act_b),
    .cap_pin(cap_pin), .cap_edge_sel(cap_edge_sel), .cap_dest(cap_dest),
    .cap_clear_en(cap_clear_en), .wr_en(wr_en), .wr_sel(wr_sel),
    .wr_data(wr_data), .pulse_out(pulse_out), .irq_cmp_a(irq_cmp_a),
    .irq_cmp_b(irq_cmp_b), .irq_capture(irq_capture),
    .irq_overflow(irq_overflow), .running_count(running_count),
    .compare_a(compare_a), .compare_b(compare_b));

  cct_pin_model i_cct_pin_model (.clk_sys(clk_sys), .pulse_out(pulse_out),
    .wave_half(wave_half), .cap_pin(cap_pin), .hi_cnt(hi_cnt));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] sel, input logic [15:0] d);
    @(negedge clk_sys);
    wr_en = 1'b1;
    wr_sel = sel;
    wr_data = d;
    @(negedge clk_sys);
    wr_en = 1'b0;
  endtask

  // Bounded wait; the global cycle ceiling catches anything that slips by
  task automatic wait_irq(input int k);
    int w;
    w = 0;
    while (irqs[k] !== 1'b1 && w < 1000) begin
      @(negedge clk_sys);
      w++;
    end
    if (w >= 1000) begin
      err_count++;
      $display("[FAIL] %0t no request on interrupt line %0d", $time, k);
    end
  endtask

  // Results appear as interrupt pulses; the oldest note is matched to each
  always @(posedge clk_sys) begin
    if (exp_q.size() > 0) begin
      if (irq_cmp_b === 1'b1) chk(hi_cnt, exp_q.pop_front());
      if (irq_capture === 1'b1) chk(compare_a, exp_q.pop_front());
      if (irq_overflow === 1'b1) chk(running_count, exp_q.pop_front());
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    {sys_rst, count_run, mode_sel, buffer_en, wr_en} = 5'b10000;
    {act_a, act_b, cap_edge_sel, wr_sel} = 9'h000;
    {cap_dest, cap_clear_en, wr_data, wave_half} = {1'b0, 1'b1, 32'h0};
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk(running_count, 16'h0000);
    chk(compare_a, 16'h0000);
    chk(compare_b, 16'h0000);
    chk(16'(pulse_out), 16'h0000);
    mode_sel = cct_pkg::MODE_PULSE;
    buffer_en = 1'b1;
    act_a = cct_pkg::ACT_HIGH;
    act_b = cct_pkg::ACT_LOW;
    wr(cct_pkg::WR_BUF_C, cct_pkg::ONESHOT_BUF_C);
    wr(cct_pkg::WR_BUF_D, cct_pkg::ONESHOT_BUF_D);
    // Shortest legal pulse first, then a random one after reloading count and both compares
    for (int i = 0; i < 2; i++) begin
      n = (i == 0) ? 16'h0001 : 16'({$random(seed)} % 40) + 16'h0002;
      wr(cct_pkg::WR_COUNT, 16'h0000);
      wr(cct_pkg::WR_CMP_A, 16'h0000);
      wr(cct_pkg::WR_CMP_B, n);
      exp_q.push_back(n);
      count_run = 1'b1;
      @(negedge clk_sys);
      chk(16'(irq_cmp_a), 16'h0001);
      chk(16'(pulse_out), 16'h0001);
      chk(compare_a, cct_pkg::ONESHOT_BUF_C);
      wait_irq(1);
      count_run = 1'b0;
      @(negedge clk_sys);
      chk(running_count, 16'h0000);
      chk(compare_b, cct_pkg::ONESHOT_BUF_D);
    end
    buffer_en = 1'b0;
    wr(cct_pkg::WR_COUNT, 16'h0000);
    wr(cct_pkg::WR_CMP_A, 16'h0005);
    wr(cct_pkg::WR_CMP_B, 16'h0005);
    count_run = 1'b1;
    repeat (20) begin
      @(negedge clk_sys);
      chk(16'(pulse_out), 16'h0000);
    end
    count_run = 1'b0;
    act_a = cct_pkg::ACT_TOGGLE;
    act_b = cct_pkg::ACT_NONE;
    wr(cct_pkg::WR_COUNT, 16'h0000);
    wr(cct_pkg::WR_CMP_A, 16'h0002);
    wr(cct_pkg::WR_CMP_B, 16'h0004);
    count_run = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wait_irq(0);
      chk(16'(pulse_out), 16'(i[0] == 1'b0));
      @(negedge clk_sys);
    end
    count_run = 1'b0;
    mode_sel = cct_pkg::MODE_NORMAL;
    cap_edge_sel = 2'h3;
    wr(cct_pkg::WR_COUNT, 16'hfffd);
    exp_q.push_back(16'h0000);
    count_run = 1'b1;
    wait_irq(2);
    count_run = 1'b0;
    wr(cct_pkg::WR_COUNT, 16'h0000);
    cap_edge_sel = cct_pkg::EDGE_RISE;
    // Half period of at least four so the preset count below wraps in time
    n = 16'({$random(seed)} % 16) + 16'h0004;
    wave_half = n;
    count_run = 1'b1;
    // First capture follows an arbitrary count, so only later ones are noted
    wait_irq(3);
    @(posedge clk_sys);
    @(negedge clk_sys);
    repeat (3) exp_q.push_back(16'(2 * n - 16'h0001));
    repeat (6 * n + 2) @(negedge clk_sys);
    // Preset the count near the top so one overflow falls inside a period;
    // the next capture then copies the wrapped count
    wait_irq(3);
    wr(cct_pkg::WR_COUNT, 16'hfffc);
    exp_q.push_back(16'h0000);
    exp_q.push_back(16'(2 * n - 16'h0007));
    repeat (2 * n + 2) @(negedge clk_sys);
    // Both edges, then falling only, into compare_b with no clear
    cap_dest = cct_pkg::CAP_TO_B;
    cap_clear_en = 1'b0;
    for (int i = 0; i < 2; i++) begin
      cap_edge_sel = (i == 0) ? cct_pkg::EDGE_BOTH : cct_pkg::EDGE_FALL;
      wait_irq(3);
      @(negedge clk_sys);
      m = compare_b;
      wait_irq(3);
      chk(compare_b - m, 16'(n << i));
      @(negedge clk_sys);
    end
    count_run = 1'b0;
    wave_half = 16'h0000;
    chk(16'(exp_q.size()), 16'h0000);
    stop_test();
  end
endmodule
